// ==== rtl/pcrc_consts.svh ====
// offsets, field positions, reset values and counts of the clock and reset control block
`ifndef PCRC_CONSTS_SVH
`define PCRC_CONSTS_SVH

// device configuration registers
`define PCRC_SYSCTL_OFS 8'h80
`define PCRC_PWRMGT_OFS 8'h84
`define PCRC_KEEP_CLOCK_BIT_BIT 1
`define PCRC_KEEP_CLOCK_BIT_RST 1'h0
`define PCRC_CRHELD_BIT 16
`define PCRC_PWR_LSB 0
`define PCRC_PWR_MSB 1
`define PCRC_PWR_RST 2'h0
`define PCRC_PMEEN_BIT 8
`define PCRC_PMEST_BIT 15

// host APB registers
`define PCRC_HCTL_OFS 8'h00
`define PCRC_HCMD_OFS 8'h04
`define PCRC_HWDATA_OFS 8'h08
`define PCRC_HRDATA_OFS 8'h0C
`define PCRC_HSTAT_OFS 8'h10
`define PCRC_HCTL_BUSRST_BIT 0
`define PCRC_HCTL_STOP_BIT 1
`define PCRC_HCMD_WR_BIT 8

// timing counts in sys_clk cycles
`define PCRC_CRUN_DRIVE 4'h2
`define PCRC_CRUN_GUARD 4'h2
`define PCRC_STOP_IDLE 4'h8
`define PCRC_BOOT_RESET 5'h10

`endif

// ==== rtl/pcrc_pkg.sv ====
// state types of the host end and of the device end of the clock and reset control block
package pcrc_pkg;

typedef enum logic [2:0] {
    CR_WATCH = 3'h1,
    CR_DRIVE = 3'h2,
    CR_GUARD = 3'h4
} pcrc_cr_t;

typedef enum logic [1:0] {
    HS_BOOT = 2'h1,
    HS_RUN = 2'h2
} pcrc_hs_t;

typedef struct packed {
    pcrc_cr_t cr;
    logic [3:0] cnt;
    logic keep_clock_bit;
    logic [1:0] pwr;
    logic pmeEn;
    logic pmeSt;
    logic ack;
    logic [31:0] rdata;
    logic outOe;
    logic crOe;
} pcrc_dev_t;

typedef struct packed {
    pcrc_hs_t hs;
    logic [4:0] bootCnt;
    logic [3:0] highCnt;
    logic busRstSw;
    logic stopReq;
    logic [7:0] addr;
    logic wr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic req;
    logic busy;
    logic crOe;
    logic stopped;
    logic busRstN;
    logic glbRstN;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
} pcrc_host_t;

endpackage

// ==== rtl/pcrc_link_if.sv ====
// pins between the host system and the card controller
`timescale 1ns/1ps
`default_nettype none
interface pcrc_link_if;
    logic busResetPinN;
    logic globalResetPinN;
    logic hostClockRunOut;
    logic hostClockRunOe;
    logic devClockRunOut;
    logic devClockRunOe;
    logic clockRunLine;
    logic cfgReq;
    logic cfgWrite;
    logic [7:0] cfgAddr;
    logic [31:0] cfgWdata;
    logic devCfgAck;
    logic [31:0] devCfgRdata;
    logic devOutOe;
    logic cfgAckLine;
    logic [31:0] cfgRdataLine;

    // open drain with pull-up: any enabled driver pulls the line low
    assign clockRunLine = !((hostClockRunOe && !hostClockRunOut) ||
                            (devClockRunOe && !devClockRunOut));
    // tristated device outputs read as zero through weak pull-downs
    assign cfgAckLine = devOutOe && devCfgAck;
    assign cfgRdataLine = devOutOe ? devCfgRdata : 32'h0;

    modport dev (
        input busResetPinN, globalResetPinN, clockRunLine,
        input cfgReq, cfgWrite, cfgAddr, cfgWdata,
        output devClockRunOut, devClockRunOe, devCfgAck, devCfgRdata, devOutOe
    );
    modport host (
        output busResetPinN, globalResetPinN, hostClockRunOut, hostClockRunOe,
        output cfgReq, cfgWrite, cfgAddr, cfgWdata,
        input clockRunLine, cfgAckLine, cfgRdataLine
    );
endinterface
`default_nettype wire

// ==== rtl/pcrc_sync.sv ====
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module pcrc_sync #(
    parameter int W = 1
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [1:0][W-1:0] st;
    logic [1:0][W-1:0] next_st;

    // stage 0 is read only by stage 1
    always_comb begin
        next_st = {st[0], d};
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign q = st[1];
endmodule // pcrc_sync
`default_nettype wire

// ==== rtl/pcrc_host.sv ====
// host end: reset sequencing, clock-stop requests and config access under APB
`timescale 1ns/1ps
`default_nettype none
`include "pcrc_consts.svh"
module pcrc_host (
    input wire logic sys_clk,
    input wire logic rst,
    pcrc_link_if.host link,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic wakeD3Capable,
    output logic clockStopped,
    output logic bootDone
);
    localparam pcrc_pkg::pcrc_host_t HOST_DEFAULT = '{
        hs: pcrc_pkg::HS_BOOT, bootCnt: `PCRC_BOOT_RESET, highCnt: 4'h0,
        busRstSw: 1'b0, stopReq: 1'b0, addr: 8'h0, wr: 1'b0, wdata: 32'h0,
        rdata: 32'h0, req: 1'b0, busy: 1'b0, crOe: 1'b1, stopped: 1'b0,
        busRstN: 1'b0, glbRstN: 1'b0, pready: 1'b0, pslverr: 1'b0, prdata: 32'h0};

    pcrc_pkg::pcrc_host_t s;
    pcrc_pkg::pcrc_host_t next_s;
    logic lineS;
    logic ackS;
    logic [31:0] rdataS;

    pcrc_sync #(.W(34)) u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .d({link.clockRunLine, link.cfgAckLine, link.cfgRdataLine}),
        .q({lineS, ackS, rdataS})
    );

    function automatic logic [32:0] hostRead(input logic [7:0] a,
                                             input pcrc_pkg::pcrc_host_t v,
                                             input logic line);
        logic [32:0] r;
        r = 33'h0;
        case (a)
            `PCRC_HCTL_OFS: begin
                r[`PCRC_HCTL_BUSRST_BIT] = v.busRstSw;
                r[`PCRC_HCTL_STOP_BIT] = v.stopReq;
            end
            `PCRC_HCMD_OFS: r[8:0] = {v.wr, v.addr};
            `PCRC_HWDATA_OFS: r[31:0] = v.wdata;
            `PCRC_HRDATA_OFS: r[31:0] = v.rdata;
            `PCRC_HSTAT_OFS: r[3:0] = {v.hs[1], line, v.stopped, v.busy};
            default: r[32] = 1'b1;
        endcase
        return r;
    endfunction

    always_comb begin
        logic [32:0] rd;
        rd = hostRead(paddr, s, lineS);
        next_s = s;
        next_s.pready = 1'b0;
        // one wait state; writes land on the edge that sees pready high
        if (psel && penable && !s.pready) begin
            next_s.pready = 1'b1;
            next_s.prdata = rd[31:0];
            next_s.pslverr = rd[32];
        end
        if (psel && penable && s.pready && pwrite) begin
            case (paddr)
                `PCRC_HCTL_OFS: begin
                    next_s.busRstSw = pwdata[`PCRC_HCTL_BUSRST_BIT];
                    next_s.stopReq = pwdata[`PCRC_HCTL_STOP_BIT];
                end
                `PCRC_HCMD_OFS: begin
                    // a command while busy is dropped; software polls busy first
                    if (!s.busy) begin
                        next_s.addr = pwdata[7:0];
                        next_s.wr = pwdata[`PCRC_HCMD_WR_BIT];
                        next_s.req = 1'b1;
                        next_s.busy = 1'b1;
                    end
                end
                `PCRC_HWDATA_OFS: next_s.wdata = pwdata;
                default: next_s.wdata = s.wdata;
            endcase
        end
        if (s.req && ackS) begin
            next_s.req = 1'b0;
            if (!s.wr) begin
                next_s.rdata = rdataS;
            end
        end else if (!s.req && s.busy && !ackS) begin
            next_s.busy = 1'b0;
        end
        case (s.hs)
            pcrc_pkg::HS_BOOT: begin
                next_s.busRstN = 1'b0;
                next_s.glbRstN = 1'b0;
                next_s.crOe = 1'b1;
                if (s.bootCnt == 5'h0) begin
                    next_s.hs = pcrc_pkg::HS_RUN;
                end else begin
                    next_s.bootCnt = s.bootCnt - 5'h1;
                end
            end
            pcrc_pkg::HS_RUN: begin
                next_s.busRstN = !s.busRstSw;
                // global reset is raised again with the bus reset only when wakeD3Capable is low
                next_s.glbRstN = wakeD3Capable ? 1'b1 : !s.busRstSw;
                if (!s.stopReq || !s.busRstN) begin
                    next_s.crOe = 1'b1;
                    next_s.highCnt = 4'h0;
                    next_s.stopped = 1'b0;
                end else begin
                    next_s.crOe = 1'b0;
                    if (!lineS) begin
                        next_s.highCnt = 4'h0;
                        next_s.stopped = 1'b0;
                    end else if (s.highCnt == `PCRC_STOP_IDLE - 4'h1) begin
                        next_s.stopped = 1'b1;
                    end else begin
                        next_s.highCnt = s.highCnt + 4'h1;
                    end
                end
            end
            default: next_s = HOST_DEFAULT;
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s <= HOST_DEFAULT;
        end else begin
            s <= next_s;
        end
    end

    assign link.busResetPinN = s.busRstN;
    assign link.globalResetPinN = s.glbRstN;
    assign link.hostClockRunOut = 1'b0;
    assign link.hostClockRunOe = s.crOe;
    assign link.cfgReq = s.req;
    assign link.cfgWrite = s.wr;
    assign link.cfgAddr = s.addr;
    assign link.cfgWdata = s.wdata;
    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign clockStopped = s.stopped;
    assign bootDone = s.hs[1];
endmodule // pcrc_host
`default_nettype wire

// ==== rtl/pcrc_device.sv ====
// device end: reset response, clock-run answer and config registers
//
// Our own choice: the four-phase request/ack config access to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pcrc_consts.svh"
module pcrc_device (
    input wire logic sys_clk,
    input wire logic rst,
    pcrc_link_if.dev link,
    input wire logic suspendMode,
    input wire logic deviceBusy,
    input wire logic pmeEvent,
    output logic keepClock,
    output logic [1:0] powerState,
    output logic pmeEnable,
    output logic pmeStatus,
    output logic deviceActive,
    output logic clockHeld
);
    localparam pcrc_pkg::pcrc_dev_t DEV_DEFAULT = '{
        cr: pcrc_pkg::CR_WATCH,
        cnt: 4'h0,
        keep_clock_bit: `PCRC_KEEP_CLOCK_BIT_RST,
        pwr: `PCRC_PWR_RST,
        pmeEn: 1'b0,
        pmeSt: 1'b0,
        ack: 1'b0,
        rdata: 32'h0,
        outOe: 1'b0,
        crOe: 1'b0
    };

    pcrc_pkg::pcrc_dev_t s;
    pcrc_pkg::pcrc_dev_t next_s;

    logic busRstS;
    logic glbRstS;
    logic lineS;
    logic reqS;
    logic wrS;
    logic [7:0] addrS;
    logic [31:0] wdataS;
    logic busAct;
    logic glbAct;
    logic needClk;

    // every pin passes two flops before any logic looks at it
    pcrc_sync #(.W(45)) u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .d({
            link.busResetPinN,
            link.globalResetPinN,
            link.clockRunLine,
            link.cfgReq,
            link.cfgWrite,
            link.cfgAddr,
            link.cfgWdata
        }),
        .q({
            busRstS,
            glbRstS,
            lineS,
            reqS,
            wrS,
            addrS,
            wdataS
        })
    );

    // synchroniser resets to zero, so both resets read as asserted at power-up
    assign busAct = !busRstS;
    assign glbAct = !glbRstS;

    // a set keep-clock bit refuses every stop request
    assign needClk = s.keep_clock_bit || deviceBusy;

    function automatic logic [31:0] regRead(input logic [7:0] a,
                                            input pcrc_pkg::pcrc_dev_t v);
        logic [31:0] r;
        r = 32'h0;
        case (a)
            `PCRC_SYSCTL_OFS: begin
                r[`PCRC_KEEP_CLOCK_BIT_BIT] = v.keep_clock_bit;
                r[`PCRC_CRHELD_BIT] = v.crOe;
            end
            `PCRC_PWRMGT_OFS: begin
                r[`PCRC_PWR_MSB:`PCRC_PWR_LSB] = v.pwr;
                r[`PCRC_PMEEN_BIT] = v.pmeEn;
                r[`PCRC_PMEST_BIT] = v.pmeSt;
            end
            default: r = 32'h0;
        endcase
        return r;
    endfunction

    always_comb begin
        next_s = s;
        next_s.outOe = 1'b1;

        // four-phase access: act once per rising request, drop ack after it
        if (reqS && !s.ack) begin
            if (wrS) begin
                if (addrS == `PCRC_SYSCTL_OFS) begin
                    next_s.keep_clock_bit = wdataS[`PCRC_KEEP_CLOCK_BIT_BIT];
                end
                if (addrS == `PCRC_PWRMGT_OFS) begin
                    next_s.pwr = wdataS[`PCRC_PWR_MSB:`PCRC_PWR_LSB];
                    next_s.pmeEn = wdataS[`PCRC_PMEEN_BIT];
                    if (wdataS[`PCRC_PMEST_BIT]) begin
                        next_s.pmeSt = 1'b0;
                    end
                end
            end
            next_s.rdata = regRead(addrS, s);
            next_s.ack = 1'b1;
        end else if (!reqS && s.ack) begin
            next_s.ack = 1'b0;
        end

        // answer a released line by pulling it low while the clock is needed
        case (s.cr)
            pcrc_pkg::CR_WATCH: begin
                if (lineS && needClk) begin
                    next_s.cr = pcrc_pkg::CR_DRIVE;
                    next_s.cnt = `PCRC_CRUN_DRIVE - 4'h1;
                    next_s.crOe = 1'b1;
                end
            end
            pcrc_pkg::CR_DRIVE: begin
                if (s.cnt == 4'h0) begin
                    next_s.cr = pcrc_pkg::CR_GUARD;
                    next_s.cnt = `PCRC_CRUN_GUARD - 4'h1;
                    next_s.crOe = 1'b0;
                end else begin
                    next_s.cnt = s.cnt - 4'h1;
                end
            end
            pcrc_pkg::CR_GUARD: begin
                // the line needs time to settle high again before we look
                if (s.cnt == 4'h0) begin
                    next_s.cr = pcrc_pkg::CR_WATCH;
                end else begin
                    next_s.cnt = s.cnt - 4'h1;
                end
            end
            default: begin
                next_s.cr = pcrc_pkg::CR_WATCH;
                next_s.cnt = 4'h0;
                next_s.crOe = 1'b0;
            end
        endcase

        // a wake event wins over a clear in the same cycle
        if (pmeEvent) begin
            next_s.pmeSt = 1'b1;
        end

        if (glbAct) begin
            next_s = DEV_DEFAULT;
        end else if (busAct) begin
            if (!suspendMode) begin
                next_s = DEV_DEFAULT;
                // wake context survives so a D3 to D0 step keeps it
                next_s.pmeEn = s.pmeEn;
                next_s.pmeSt = s.pmeSt || pmeEvent;
            end
            // suspend only shields register contents, not the pins
            next_s.outOe = 1'b0;
            next_s.crOe = 1'b0;
            next_s.ack = 1'b0;
            next_s.cr = pcrc_pkg::CR_WATCH;
            next_s.cnt = 4'h0;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s <= DEV_DEFAULT;
        end else begin
            s <= next_s;
        end
    end

    assign link.devClockRunOut = 1'b0;
    assign link.devClockRunOe = s.crOe;
    assign link.devCfgAck = s.ack;
    assign link.devCfgRdata = s.rdata;
    assign link.devOutOe = s.outOe;

    assign keepClock = s.keep_clock_bit;
    assign powerState = s.pwr;
    assign pmeEnable = s.pmeEn;
    assign pmeStatus = s.pmeSt;
    assign deviceActive = s.outOe;
    assign clockHeld = s.crOe;
endmodule // pcrc_device
`default_nettype wire

// ==== sim/pcrc_link_properties.sv ====
// concurrent checks on the pins between the host and the card controller
`timescale 1ns/1ps
`default_nettype none
module pcrc_link_properties (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic busResetPinN,
    input wire logic globalResetPinN,
    input wire logic hostClockRunOut,
    input wire logic hostClockRunOe,
    input wire logic devClockRunOe,
    input wire logic clockRunLine,
    input wire logic cfgReq,
    input wire logic devCfgAck,
    input wire logic devOutOe
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // two sync flops plus the state register: four low samples leave no doubt
    sequence s_busLow; !busResetPinN [*4]; endsequence
    sequence s_glbLow; !globalResetPinN [*4]; endsequence
    sequence s_pinsUp; (busResetPinN && globalResetPinN) [*4]; endsequence
    sequence s_pull2; devClockRunOe ##1 !devClockRunOe; endsequence
    property p_busOff; s_busLow |-> !devOutOe && !devClockRunOe && !devCfgAck; endproperty
    a_busOff: assert property (p_busOff) else $error("device drives under bus reset");
    property p_glbOff; s_glbLow |-> !devOutOe && !devClockRunOe; endproperty
    a_glbOff: assert property (p_glbOff) else $error("device drives under global reset");
    property p_oeUp; s_pinsUp |-> devOutOe; endproperty
    a_oeUp: assert property (p_oeUp) else $error("outputs stay off after reset");
    property p_pull; $rose(devClockRunOe) |=> s_pull2; endproperty
    a_pull: assert property (p_pull) else $error("clock-run pull not two cycles");
    property p_pullCause; $rose(devClockRunOe) |-> $past(clockRunLine); endproperty
    a_pullCause: assert property (p_pullCause) else $error("pull without stop request");
    property p_hostHold; !busResetPinN [*2] |-> hostClockRunOe; endproperty
    a_hostHold: assert property (p_hostHold) else $error("host released line in reset");
    property p_odOut; hostClockRunOe |-> !hostClockRunOut && !clockRunLine; endproperty
    a_odOut: assert property (p_odOut) else $error("host drives clock-run high");
    property p_ackRise; $rose(cfgReq) && devOutOe |-> ##[2:4] devCfgAck; endproperty
    a_ackRise: assert property (p_ackRise) else $error("config request not taken");
    property p_ackCause; $rose(devCfgAck) |-> cfgReq; endproperty
    a_ackCause: assert property (p_ackCause) else $error("ack without request");
    property p_ackDrop; $fell(cfgReq) |-> ##[1:5] !devCfgAck; endproperty
    a_ackDrop: assert property (p_ackDrop) else $error("ack held after request");
endmodule // pcrc_link_properties
`default_nettype wire

// ==== sim/tb_pci_clock_reset_control.sv ====
// self-checking bench: host and device joined over the link, driven over APB
`timescale 1ns/1ps
`default_nettype none
`include "pcrc_consts.svh"
module tb_pci_clock_reset_control;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic wakeD3Capable = 1'b1;
    logic clockStopped;
    logic bootDone;
    logic suspendMode = 1'b0;
    logic deviceBusy = 1'b0;
    logic pmeEvent = 1'b0;
    logic keepClock;
    logic [1:0] powerState;
    logic pmeEnable;
    logic pmeStatus;
    logic deviceActive;
    logic clockHeld;
    logic [31:0] rd;
    logic er;
    logic held;
    int n_errors = 0;
    int total_checks = 0;

    always #10 sys_clk = ~sys_clk;

    pcrc_link_if link ();
    pcrc_host i_pcrc_host (.sys_clk(sys_clk), .rst(rst), .link(link), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .wakeD3Capable(wakeD3Capable),
        .clockStopped(clockStopped), .bootDone(bootDone));
    pcrc_device i_pcrc_device (.sys_clk(sys_clk), .rst(rst), .link(link),
        .suspendMode(suspendMode), .deviceBusy(deviceBusy), .pmeEvent(pmeEvent),
        .keepClock(keepClock), .powerState(powerState), .pmeEnable(pmeEnable),
        .pmeStatus(pmeStatus), .deviceActive(deviceActive), .clockHeld(clockHeld));
    pcrc_link_properties i_pcrc_link_properties (.sys_clk(sys_clk), .rst(rst),
        .busResetPinN(link.busResetPinN), .globalResetPinN(link.globalResetPinN),
        .hostClockRunOut(link.hostClockRunOut), .hostClockRunOe(link.hostClockRunOe),
        .devClockRunOe(link.devClockRunOe), .clockRunLine(link.clockRunLine),
        .cfgReq(link.cfgReq), .devCfgAck(link.devCfgAck), .devOutOe(link.devOutOe));

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one APB transfer; the request stands until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        // no cycle count assumed here: only the watchdog ends a hung wait
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // config access through the host command registers; waits on the busy flag
    task automatic cfg(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        apb(1'b1, `PCRC_HWDATA_OFS, d);
        apb(1'b1, `PCRC_HCMD_OFS, {23'h0, wr, a});
        do begin
            apb(1'b0, `PCRC_HSTAT_OFS, 32'h0);
            n++;
        end while (rd[0] !== 1'b0 && n < 40);
        chk("cfg busy", 32'h0, {31'h0, rd[0]});
        apb(1'b0, `PCRC_HRDATA_OFS, 32'h0);
    endtask

    // pulse the bus reset from the host control register
    task automatic bus_reset();
        apb(1'b1, `PCRC_HCTL_OFS, 32'h1);
        repeat (6) @(posedge sys_clk);
        chk("active in reset", 32'h0, {31'h0, deviceActive});
        chk("oe in reset", 32'h0, {31'h0, link.devOutOe});
        chk("held in reset", 32'h0, {31'h0, clockHeld});
        chk("global pin", {31'h0, wakeD3Capable}, {31'h0, link.globalResetPinN});
        apb(1'b1, `PCRC_HCTL_OFS, 32'h0);
        repeat (6) @(posedge sys_clk);
    endtask

    task automatic test_done();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        n_errors++;
        test_done();
    end

    initial begin
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (30) @(posedge sys_clk);
        apb(1'b0, `PCRC_HSTAT_OFS, 32'h0);
        chk("boot done", 32'h1, {31'h0, rd[3]});
        chk("boot pin", 32'h1, {31'h0, bootDone});
        cfg(1'b0, `PCRC_SYSCTL_OFS, 32'h0);
        chk("keep clock reset", 32'h0, {31'h0, rd[`PCRC_KEEP_CLOCK_BIT_BIT]});
        apb(1'b0, 8'h14, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, er});
        chk("unmapped data", 32'h0, rd);
        // clock-run enabled: an idle device lets the clock stop
        apb(1'b1, `PCRC_HCTL_OFS, 32'h2);
        repeat (30) @(posedge sys_clk);
        chk("stop granted", 32'h1, {31'h0, clockStopped});
        apb(1'b1, `PCRC_HCTL_OFS, 32'h0);
        repeat (6) @(posedge sys_clk);
        chk("stop withdrawn", 32'h0, {31'h0, clockStopped});
        cfg(1'b1, `PCRC_SYSCTL_OFS, 32'h2);
        cfg(1'b0, `PCRC_SYSCTL_OFS, 32'h0);
        chk("keep clock set", 32'h1, {31'h0, rd[`PCRC_KEEP_CLOCK_BIT_BIT]});
        chk("keep clock pin", 32'h1, {31'h0, keepClock});
        // keep-clock set: the device refuses every stop request
        apb(1'b1, `PCRC_HCTL_OFS, 32'h2);
        repeat (40) @(posedge sys_clk);
        chk("stop refused", 32'h0, {31'h0, clockStopped});
        apb(1'b1, `PCRC_HCTL_OFS, 32'h0);
        cfg(1'b1, `PCRC_PWRMGT_OFS, 32'h103);
        @(posedge sys_clk);
        pmeEvent <= 1'b1;
        @(posedge sys_clk);
        pmeEvent <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk("pme status", 32'h1, {31'h0, pmeStatus});
        chk("power state", 32'h3, {30'h0, powerState});
        suspendMode <= 1'b1;
        bus_reset();
        cfg(1'b0, `PCRC_SYSCTL_OFS, 32'h0);
        chk("suspend keeps", 32'h1, {31'h0, rd[`PCRC_KEEP_CLOCK_BIT_BIT]});
        suspendMode <= 1'b0;
        bus_reset();
        cfg(1'b0, `PCRC_SYSCTL_OFS, 32'h0);
        chk("bus reset clears", 32'h0, {31'h0, rd[`PCRC_KEEP_CLOCK_BIT_BIT]});
        chk("power default", 32'h0, {30'h0, powerState});
        chk("pme kept", 32'h3, {30'h0, pmeEnable, pmeStatus});
        // keep-clock now cleared, but a busy device still refuses the stop
        deviceBusy <= 1'b1;
        held = 1'b0;
        apb(1'b1, `PCRC_HCTL_OFS, 32'h2);
        repeat (40) begin
            @(posedge sys_clk);
            if (clockHeld === 1'b1) begin
                held = 1'b1;
            end
        end
        chk("busy stop refused", 32'h0, {31'h0, clockStopped});
        chk("clock held", 32'h1, {31'h0, held});
        apb(1'b1, `PCRC_HCTL_OFS, 32'h0);
        deviceBusy <= 1'b0;
        // without wake from D3 the global reset follows the bus reset
        wakeD3Capable <= 1'b0;
        bus_reset();
        chk("pme cleared", 32'h0, {30'h0, pmeEnable, pmeStatus});
        chk("active again", 32'h1, {31'h0, deviceActive});
        test_done();
    end
endmodule // tb_pci_clock_reset_control
`default_nettype wire
